// *** core/iem_defines.svh ***
`ifndef IEM_DEFINES_SVH
`define IEM_DEFINES_SVH
`define IEM_XLEN          32
`define IEM_REG_AW        5
`define IEM_SET_AW        3
`define IEM_NUM_SETS      8
`define IEM_ACC_AW        2
`define IEM_NUM_ACC       4
`define IEM_CNT_W         6
`define IEM_MUL_LAT       5
`define IEM_DIV_SKIP8     23
`define IEM_DIV_SKIP16    15
`define IEM_DIV_SKIP24    7
`define IEM_DIV_LAT8      12
`define IEM_DIV_LAT16     20
`define IEM_DIV_LAT24     28
`define IEM_DIV_LAT32     36
`define IEM_DIV_SGN_EXTRA 2
`endif

// *** core/iem_pkg.sv ***
package iem_pkg;
`include "iem_defines.svh"
    typedef enum logic [4:0] {
        OP_NOP, OP_AND, OP_OR, OP_XOR, OP_NOR, OP_SLL, OP_SRL, OP_SRA, OP_ADD, OP_SUB,
        OP_CLZ, OP_CLO, OP_MULT, OP_MULTU, OP_MADD, OP_MADDU, OP_MSUB, OP_MSUBU, OP_MUL,
        OP_DIV, OP_DIVU, OP_MFHI, OP_MFLO
    } iem_op_e;

    typedef enum logic {DIV_IDLE, DIV_RUN} iem_div_e;

    typedef struct packed {
        logic                   valid;
        iem_op_e                op;
        logic [`IEM_SET_AW-1:0] set;
        logic [`IEM_REG_AW-1:0] rs;
        logic [`IEM_REG_AW-1:0] rt;
        logic [`IEM_REG_AW-1:0] rd;
        logic [`IEM_REG_AW-1:0] shamt;
        logic [`IEM_ACC_AW-1:0] acc;
    } iem_req_s;

    typedef struct packed {
        logic                   valid;
        logic [`IEM_SET_AW-1:0] set;
        logic [`IEM_REG_AW-1:0] rd;
        logic [`IEM_XLEN-1:0]   data;
    } iem_wb_s;

    typedef struct packed {
        logic                     valid;
        logic                     to_gpr;
        logic                     accum;
        logic                     neg;
        logic [`IEM_ACC_AW-1:0]   acc;
        logic [`IEM_SET_AW-1:0]   set;
        logic [`IEM_REG_AW-1:0]   rd;
        logic [2*`IEM_XLEN-1:0]   prod;
    } iem_mst_s;

    typedef struct packed {
        iem_div_e               st;
        logic                   qneg;
        logic                   rneg;
        logic [`IEM_ACC_AW-1:0] acc;
        logic [`IEM_CNT_W-1:0]  cnt;
        logic [`IEM_CNT_W-1:0]  iter;
        logic [`IEM_XLEN-1:0]   rem;
        logic [`IEM_XLEN-1:0]   quot;
        logic [`IEM_XLEN-1:0]   dvs;
    } iem_div_s;

    typedef struct packed {
        iem_wb_s                                    wb;
        iem_mst_s [`IEM_MUL_LAT-2:0]                mst;
        logic [`IEM_NUM_ACC-1:0][`IEM_XLEN-1:0]     hi;
        logic [`IEM_NUM_ACC-1:0][`IEM_XLEN-1:0]     lo;
        iem_div_s                                   div;
    } iem_state_s;
endpackage

// *** core/iem_exec_unit.sv ***
`timescale 1ns/1ps
`include "iem_defines.svh"
module iem_exec_unit #(
    parameter int unsigned NUM_SETS = `IEM_NUM_SETS
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  iem_pkg::iem_req_s req,
    output logic            stall,
    output iem_pkg::iem_wb_s  wb,
    output logic            div_busy
);
    import iem_pkg::*;

    localparam int STG = `IEM_MUL_LAT - 1;

    iem_state_s            s_q;
    iem_state_s            s_d;
    logic [`IEM_XLEN-1:0]  rf_q [0:NUM_SETS*32-1];
    logic [`IEM_XLEN-1:0]  rs_val;
    logic [`IEM_XLEN-1:0]  rt_val;
    logic                  is_mdu;
    logic                  wr_gpr;
    logic                  hz_gpr;
    logic                  hz_acc;
    logic                  sx;
    logic signed [65:0]    prod_full;
    logic [`IEM_XLEN-1:0]  mag;
    logic [`IEM_XLEN-1:0]  dvs_mag;
    logic [`IEM_CNT_W-1:0] skip;
    logic [`IEM_CNT_W-1:0] lat;
    logic [32:0]           trial;
    logic [32:0]           diff;
    logic [63:0]           acc_v;
    logic [63:0]           sum;
    iem_mst_s              last;

    function automatic logic [`IEM_CNT_W-1:0] lead_count(input logic [31:0] v,
                                                         input logic ones);
        logic [`IEM_CNT_W-1:0] n;
        logic                  go;
        n  = '0;
        go = 1'b1;
        for (int i = 31; i >= 0; i--)
        begin
            if (go && (v[i] == ones))
                n = n + 6'h01;
            else
                go = 1'b0;
        end
        return n;
    endfunction

    function automatic logic [31:0] bypass(input iem_wb_s w, input logic [2:0] set,
                                           input logic [4:0] r, input logic [31:0] raw);
        return (w.valid && (w.set == set) && (w.rd == r)) ? w.data : raw;
    endfunction

    function automatic logic [31:0] absval(input logic [31:0] v, input logic sgn);
        return (sgn && v[31]) ? (32'h0 - v) : v;
    endfunction

    // Two read ports with bypass.
    // read bypass
    assign rs_val = bypass(s_q.wb, req.set, req.rs, rf_q[{req.set, req.rs}]);
    assign rt_val = bypass(s_q.wb, req.set, req.rt, rf_q[{req.set, req.rt}]);

    assign last     = s_q.mst[STG-1];
    assign wb       = s_q.wb;
    assign div_busy = (s_q.div.st == DIV_RUN);

    always_comb
    begin
        is_mdu = req.op inside {OP_MULT, OP_MULTU, OP_MADD, OP_MADDU, OP_MSUB, OP_MSUBU,
                                OP_MUL, OP_DIV, OP_DIVU, OP_MFHI, OP_MFLO};
        wr_gpr = req.op inside {[OP_AND:OP_CLO], OP_MFHI, OP_MFLO};
        hz_gpr = 1'b0;
        hz_acc = 1'b0;
        for (int i = 0; i < STG; i++)
        begin
            if (s_q.mst[i].valid && s_q.mst[i].to_gpr && (s_q.mst[i].set == req.set) &&
                ((s_q.mst[i].rd == req.rs) || (s_q.mst[i].rd == req.rt) ||
                 (s_q.mst[i].rd == req.rd)))
                hz_gpr = 1'b1;
            if (s_q.mst[i].valid && !s_q.mst[i].to_gpr && (s_q.mst[i].acc == req.acc) &&
                (req.op inside {OP_MFHI, OP_MFLO}))
                hz_acc = 1'b1;
        end
        stall = req.valid && ((is_mdu && div_busy) || hz_gpr || hz_acc ||
                              (wr_gpr && last.valid && last.to_gpr));
    end

    always_comb
    begin
        sx = req.op inside {OP_MULT, OP_MADD, OP_MSUB, OP_MUL, OP_DIV};
        prod_full = $signed({sx & rs_val[31], rs_val}) * $signed({sx & rt_val[31], rt_val});
        mag     = absval(rs_val, sx);
        dvs_mag = absval(rt_val, sx);
        if (mag[31:8] == 24'h0)
            skip = 6'(`IEM_DIV_SKIP8);
        else if (mag[31:16] == 16'h0)
            skip = 6'(`IEM_DIV_SKIP16);
        else if (mag[31:24] == 8'h0)
            skip = 6'(`IEM_DIV_SKIP24);
        else
            skip = 6'h00;
        case (skip)
            6'(`IEM_DIV_SKIP8):  lat = 6'(`IEM_DIV_LAT8);
            6'(`IEM_DIV_SKIP16): lat = 6'(`IEM_DIV_LAT16);
            6'(`IEM_DIV_SKIP24): lat = 6'(`IEM_DIV_LAT24);
            default:             lat = 6'(`IEM_DIV_LAT32);
        endcase
        if (sx)
            lat = lat + 6'(`IEM_DIV_SGN_EXTRA);
    end

    always_comb
    begin
        s_d   = s_q;
        s_d.wb = '0;
        trial = '0;
        diff  = '0;
        acc_v = '0;
        sum   = '0;
        for (int i = STG - 1; i > 0; i--)
            s_d.mst[i] = s_q.mst[i-1];
        s_d.mst[0] = '0;
        if (last.valid && last.to_gpr)
        begin
            s_d.wb.valid = 1'b1;
            s_d.wb.set   = last.set;
            s_d.wb.rd    = last.rd;
            s_d.wb.data  = last.prod[31:0];
        end
        else if (last.valid)
        begin
            acc_v = {s_q.hi[last.acc], s_q.lo[last.acc]};
            if (!last.accum)
                sum = last.prod;
            else if (last.neg)
                sum = acc_v - last.prod;
            else
                sum = acc_v + last.prod;
            s_d.hi[last.acc] = sum[63:32];
            s_d.lo[last.acc] = sum[31:0];
        end

        case (s_q.div.st)
            DIV_IDLE:
            begin
            end
            DIV_RUN:
            begin
                if (s_q.div.iter != 6'h00)
                begin
                    trial = {s_q.div.rem, s_q.div.quot[31]};
                    diff  = trial - {1'b0, s_q.div.dvs};
                    s_d.div.iter = s_q.div.iter - 6'h01;
                    s_d.div.quot = {s_q.div.quot[30:0], ~diff[32]};
                    s_d.div.rem  = diff[32] ? trial[31:0] : diff[31:0];
                end
                s_d.div.cnt = s_q.div.cnt - 6'h01;
                if (s_q.div.cnt == 6'h01)
                begin
                    s_d.hi[s_q.div.acc] = s_q.div.rneg ? (32'h0 - s_q.div.rem) : s_q.div.rem;
                    s_d.lo[s_q.div.acc] = s_q.div.qneg ? (32'h0 - s_q.div.quot) : s_q.div.quot;
                    s_d.div.st = DIV_IDLE;
                end
            end
            default:
                s_d.div.st = DIV_IDLE;
        endcase

        if (req.valid && !stall)
        begin
            case (req.op)
                OP_AND: s_d.wb.data = rs_val & rt_val;
                OP_OR:  s_d.wb.data = rs_val | rt_val;
                OP_XOR: s_d.wb.data = rs_val ^ rt_val;
                OP_NOR: s_d.wb.data = ~(rs_val | rt_val);
                OP_SLL: s_d.wb.data = rt_val << req.shamt;
                OP_SRL: s_d.wb.data = rt_val >> req.shamt;
                OP_SRA: s_d.wb.data = $unsigned($signed(rt_val) >>> req.shamt);
                OP_ADD: s_d.wb.data = rs_val + rt_val;
                OP_SUB: s_d.wb.data = rs_val - rt_val;
                OP_CLZ: s_d.wb.data = {26'h0, lead_count(rs_val, 1'b0)};
                OP_CLO: s_d.wb.data = {26'h0, lead_count(rs_val, 1'b1)};
                OP_MFHI: s_d.wb.data = s_q.hi[req.acc];
                OP_MFLO: s_d.wb.data = s_q.lo[req.acc];
                OP_DIV, OP_DIVU:
                begin
                    s_d.div.st   = DIV_RUN;
                    s_d.div.qneg = sx && (rs_val[31] ^ rt_val[31]);
                    s_d.div.rneg = sx && rs_val[31];
                    s_d.div.acc  = req.acc;
                    s_d.div.cnt  = lat - 6'h01;
                    s_d.div.iter = 6'(`IEM_XLEN) - skip;
                    s_d.div.rem  = '0;
                    s_d.div.quot = mag << skip;
                    s_d.div.dvs  = dvs_mag;
                end
                OP_NOP:
                begin
                end
                default:
                begin
                    s_d.mst[0].valid  = 1'b1;
                    s_d.mst[0].to_gpr = (req.op == OP_MUL);
                    s_d.mst[0].accum  = req.op inside {OP_MADD, OP_MADDU, OP_MSUB, OP_MSUBU};
                    s_d.mst[0].neg    = req.op inside {OP_MSUB, OP_MSUBU};
                    s_d.mst[0].acc    = req.acc;
                    s_d.mst[0].set    = req.set;
                    s_d.mst[0].rd     = req.rd;
                    s_d.mst[0].prod   = prod_full[63:0];
                end
            endcase
            if (wr_gpr)
            begin
                s_d.wb.valid = 1'b1;
                s_d.wb.set   = req.set;
                s_d.wb.rd    = req.rd;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    always_ff @(posedge core_clk)
    begin
        if (s_q.wb.valid)
            rf_q[{s_q.wb.set, s_q.wb.rd}] <= s_q.wb.data;
    end
endmodule

// *** verif/iem_exec_checker.sv ***
`timescale 1ns/1ps
module iem_exec_checker
    import iem_pkg::*;
#(
    parameter int unsigned NUM_SETS = 8
) (
    input wire logic         core_clk,
    input wire logic         rst_n,
    input iem_pkg::iem_req_s req,
    input wire logic         stall,
    input iem_pkg::iem_wb_s  wb,
    input wire logic         div_busy
);
    logic       tk;
    logic [3:0] mh_q;
    logic [5:0] bc_q;
    assign tk = req.valid && !stall;
    always_ff @(posedge core_clk)
    begin
        mh_q <= rst_n ? {mh_q[2:0], tk && req.op == OP_MUL} : 4'h0;
        bc_q <= (rst_n && div_busy) ? bc_q + 6'h01 : 6'h00;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_alu_one: assert property (tk && req.op inside {[OP_AND:OP_CLO]} |=>
        wb.valid && wb.rd == $past(req.rd)) else $error("alu result late");
    chk_mul_five: assert property (tk && req.op == OP_MUL |->
        ##5 wb.valid && wb.rd == $past(req.rd, 5)) else $error("mul result late");
    chk_div_stall: assert property (req.valid && div_busy && req.op >= OP_MULT |->
        stall) else $error("mdu op taken during divide");
    chk_div_start: assert property (tk && req.op inside {OP_DIV, OP_DIVU} |=>
        div_busy [*8]) else $error("divider not running");
    chk_div_len: assert property ($fell(div_busy) && $past(rst_n) |->
        bc_q inside {6'h0b, 6'h0d, 6'h13, 6'h15, 6'h1b, 6'h1d, 6'h23, 6'h25})
        else $error("divide length wrong");
    chk_alu_free: assert property (req.valid && req.op inside {[OP_AND:OP_CLO]}
        && mh_q == 4'h0 |-> !stall) else $error("alu op stalled");
    chk_mult_free: assert property (req.valid && req.op inside {[OP_MULT:OP_MSUBU]}
        && !div_busy && mh_q == 4'h0 |-> !stall) else $error("multiply refused");
    chk_mul_haz: assert property (req.valid && mh_q[0] && req.set == $past(req.set)
        && req.rs == $past(req.rd) |-> stall) else $error("mul result read early");
endmodule
bind iem_exec_unit iem_exec_checker #(.NUM_SETS(NUM_SETS)) iem_exec_checker_inst (
    .core_clk(core_clk), .rst_n(rst_n), .req(req), .stall(stall), .wb(wb),
    .div_busy(div_busy));

// *** verif/iem_issue_model.sv ***
`timescale 1ns/1ps
module iem_issue_model
    import iem_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          stall,
    output iem_pkg::iem_req_s req
);
    int cyc = 0;
    initial req = '0;
    always @(posedge core_clk) cyc <= cyc + 1;
    // Requests change at falling edges; a taken one stands until the next request or idle.
    task automatic send(input iem_req_s r, output int tk, output int w);
        @(negedge core_clk);
        req <= r;
        w = 0;
        #1;
        while (stall !== 1'b0 && w < 100)
        begin
            @(negedge core_clk);
            #1;
            w++;
        end
        tk = cyc;
        @(posedge core_clk);
    endtask
    task automatic idle();
        @(negedge core_clk);
        req.valid <= 1'b0;
    endtask
endmodule

// *** verif/tb_integer_exec_mul_div_unit.sv ***
`timescale 1ns/1ps
module tb_integer_exec_mul_div_unit;
    import iem_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    iem_req_s    req;
    logic        stall;
    iem_wb_s     wb;
    logic        div_busy;
    int          fails = 0;
    int          num_checks = 0;
    logic [31:0] gm[8][32];
    logic [63:0] acc[4] = '{default: 64'h0};
    logic [39:0] exp_q[int];
    always #10 core_clk = ~core_clk;
    iem_issue_model iem_issue_model_inst (.core_clk(core_clk), .stall(stall), .req(req));
    iem_exec_unit iem_exec_unit_inst (.core_clk(core_clk), .rst_n(rst_n), .req(req),
        .stall(stall), .wb(wb), .div_busy(div_busy));
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    always @(negedge core_clk)
        if (rst_n && wb.valid !== 1'b0)
        begin
            check({wb.set, wb.rd, wb.data}, exp_q[iem_issue_model_inst.cyc]);
            exp_q.delete(iem_issue_model_inst.cyc);
        end
    task automatic op(input iem_op_e o, input int s, input int rs, input int rt,
                      input int rd, input int sh, output int w);
        iem_req_s    r;
        int          tk;
        int          n;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] v;
        logic [63:0] p;
        logic [63:0] ps;
        logic [63:0] pu;
        r = '{1'b1, o, s[2:0], rs[4:0], rt[4:0], rd[4:0], sh[4:0], sh[1:0]};
        a = gm[s][rs];
        b = gm[s][rt];
        ps = 64'($signed(a)) * 64'($signed(b));
        pu = {32'h0, a} * {32'h0, b};
        p = acc[sh[1:0]];
        n = 1;
        iem_issue_model_inst.send(r, tk, w);
        case (o)
            OP_AND: v = a & b;
            OP_OR: v = a | b;
            OP_XOR: v = a ^ b;
            OP_NOR: v = ~(a | b);
            OP_SLL: v = b << sh;
            OP_SRL: v = b >> sh;
            OP_SRA: v = $signed(b) >>> sh;
            OP_ADD: v = a + b;
            OP_SUB: v = a - b;
            OP_CLZ, OP_CLO:
            begin
                v = 32'h0;
                while (v < 32 && a[31 - v] == (o == OP_CLO)) v++;
            end
            OP_MUL:
            begin
                n = 5;
                v = a * b;
            end
            OP_MULT: p = ps;
            OP_MULTU: p = pu;
            OP_MADD: p = p + ps;
            OP_MADDU: p = p + pu;
            OP_MSUB: p = p - ps;
            OP_MSUBU: p = p - pu;
            OP_DIV: p = {$signed(a) % $signed(b), $signed(a) / $signed(b)};
            OP_DIVU: p = {a % b, a / b};
            OP_MFHI: v = p[63:32];
            OP_MFLO: v = p[31:0];
            default: ;
        endcase
        if (o >= OP_MULT && o <= OP_DIVU && o != OP_MUL)
            acc[sh[1:0]] = p;
        else if (o != OP_NOP)
        begin
            gm[s][rd] = v;
            exp_q[tk + n] = {r.set, r.rd, v};
        end
    endtask
    task automatic t_alu();
        int w;
        op(OP_MFLO, 0, 0, 0, 1, 0, w);
        op(OP_NOR, 0, 1, 1, 2, 0, w);
        op(OP_SUB, 0, 1, 2, 3, 0, w);
        op(OP_SLL, 0, 0, 3, 4, 31, w);
        op(OP_SRA, 0, 0, 4, 5, 7, w);
        op(OP_XOR, 0, 5, 2, 6, 0, w);
        check(w, 0);
        for (int i = 1; i < 12; i++)
        begin
            op(iem_op_e'(i), 0, 5, 6, 10 + i, 9, w);
            check(w, 0);
        end
    endtask
    task automatic t_sets();
        int w;
        for (int s = 1; s < 8; s++)
        begin
            op(OP_MFLO, s, 0, 0, 1, 0, w);
            op(OP_NOR, s, 1, 1, 6, 0, w);
            op(OP_SLL, s, 0, 6, 6, s, w);
        end
        for (int s = 0; s < 8; s++)
            op(OP_OR, s, 6, 6, 7, 0, w);
    endtask
    task automatic t_mul();
        int w;
        for (int i = 0; i < 8; i++)
        begin
            op(iem_op_e'(12 + i % 6), 0, 5, 6, 0, i % 4, w);
            check(w, 0);
        end
        for (int k = 0; k < 4; k++)
        begin
            op(OP_MFHI, 0, 0, 0, 22, k, w);
            op(OP_MFLO, 0, 0, 0, 23, k, w);
        end
        op(OP_MUL, 0, 5, 6, 24, 0, w);
        op(OP_ADD, 0, 24, 3, 25, 0, w);
        check(w, 4);
        op(OP_MUL, 0, 24, 3, 26, 0, w);
        op(OP_MUL, 0, 5, 6, 27, 0, w);
        check(w, 0);
        for (int i = 0; i < 4; i++)
        begin
            op(i % 2 ? OP_NOP : OP_MULT, 0, 5, 6, 0, 0, w);
            check(w, 0);
        end
        iem_issue_model_inst.idle();
        repeat (6) @(negedge core_clk);
    endtask
    task automatic t_div();
        int w;
        int k;
        op(OP_SLL, 0, 0, 3, 8, 1, w);
        for (int i = 0; i < 8; i++)
        begin
            k = i / 2;
            op(OP_SRL, 0, 0, 2, 9, 25 - 8 * k, w);
            op(i % 2 ? OP_DIV : OP_DIVU, 0, 9, 8, 0, k, w);
            op(OP_ADD, 0, 9, 9, 10, 0, w);
            check(w, 0);
            op(OP_MFLO, 0, 0, 0, 28, k, w);
            check(w, 10 + 8 * k + 2 * (i % 2));
            op(OP_MFHI, 0, 0, 0, 29, k, w);
        end
    endtask
    task automatic stop_test();
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        t_alu();
        t_sets();
        t_mul();
        t_div();
        iem_issue_model_inst.idle();
        repeat (8) @(negedge core_clk);
        check(exp_q.num(), 0);
        stop_test();
    end
    initial
    begin
        #100000;
        fails++;
        stop_test();
    end
endmodule
